// file: rtl/ppfs_pkg.sv
// Types shared by the pin function select block
package ppfs_pkg;

  // Drive of one pad: level and output enable
  typedef struct packed {
    logic out;
    logic oe;
  } ppfs_pad_t;

  // Receive lines handed to the internal peripherals
  typedef struct packed {
    logic enh_serial_rx;
    logic basic_serial_rx;
    logic capcomp_four_rx;
    logic spi_main_out_rx;
    logic spi_clock_rx;
    logic i2c_master_clock_rx;
    logic i2c_slave_two_clock_rx;
  } ppfs_rx_t;

endpackage

// file: rtl/ppfs_regs.svh
// Register offsets, field positions, reset values for the pin function select block
//
// Functional notes
// - First pin register at index 0xA057, read/write, resets to zero.
// - Second pin register at index 0xA058, read/write, reads last written value.
// - Second pin bit 7 drives pin from PWM channel five.
// - Second pin bit 6 routes pin to enhanced serial receive input.
// - Second pin bit 5 routes pin to basic serial receive input.
// - Second pin bit 4 connects pin bidirectionally to capture/compare four I/O.
// - Second pin bit 3 connects pin as SPI MOSI, direction from SPI role.
// - Bit 2 makes the pin level an input to shared interrupt one.
// - Several pins selected for shared interrupt one are combined onto it.
// - Bit 1 makes pin level an input to shared interrupt zero; several allowed.
// - One pin may feed both shared interrupts at once.
// - Bit 0 enables plain GPIO; disabled while zero, the reset value.
`ifndef PPFS_REGS_SVH
`define PPFS_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PPFS_PIN_A_IDX 16'hA057
`define PPFS_PIN_B_IDX 16'hA058
`define PPFS_IRQ_STAT_IDX 16'hA060
`define PPFS_IRQ_MASK_IDX 16'hA061
`define PPFS_PIN_STATE_IDX 16'hA062

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PPFS_PIN_RST 8'h00
`define PPFS_IRQ_RST 2'h0

// ----------------------------------------------------------------
// Field positions, common to both pins
// ----------------------------------------------------------------
`define PPFS_GENERAL_IO_SEL 0
`define PPFS_IRQ_ZERO_SRC_SEL 1
`define PPFS_IRQ_ONE_SRC_SEL 2
// First pin
`define PPFS_SPI_CLOCK_SEL 3
`define PPFS_BUZZER_OUT_SEL 4
`define PPFS_I2C_SLAVE_TWO_CLOCK_SEL 5
`define PPFS_I2C_MASTER_CLOCK_SEL 6
`define PPFS_PWM_CH_FOUR_OUT_SEL 7
// Second pin
`define PPFS_SPI_MAIN_OUT_SEL 3
`define PPFS_CAPCOMP_FOUR_IO_SEL 4
`define PPFS_BASIC_SERIAL_RX_SEL 5
`define PPFS_ENH_SERIAL_RX_SEL 6
`define PPFS_PWM_CH_FIVE_OUT_SEL 7

// Status and mask bit positions
`define PPFS_EV_IRQ_ZERO 0
`define PPFS_EV_IRQ_ONE 1

`endif

// file: rtl/ppfs_sync.sv
// Three-stage pin input synchroniser with agreement filter
`timescale 1ns/1ps
module ppfs_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Asynchronous levels and filtered result
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_out
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] level_next;

  // A change counts only once stages two and three agree, per bit
  assign level_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (level_out & (s2_reg ^ s3_reg));

  // Shift chain; first stage feeds only the second
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      level_out <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_out <= level_next;
    end
  end

endmodule

// file: rtl/ppfs_top.sv
// Function select and routing for two port pins, with APB registers
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "ppfs_regs.svh"
module ppfs_top
  import ppfs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [17:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // First pin pad
  input wire logic pin_a_in,
  output logic pin_a_out,
  output logic pin_a_oe_out,
  // Second pin pad
  input wire logic pin_b_in,
  output logic pin_b_out,
  output logic pin_b_oe_out,
  // Peripheral drive sources
  input wire logic pwm_ch_four_in,
  input wire logic pwm_ch_five_in,
  input wire logic buzzer_in,
  input wire logic i2c_master_clock_low_in,
  input wire logic i2c_slave_two_clock_low_in,
  input wire logic spi_is_master_in,
  input wire logic spi_clock_in,
  input wire logic spi_main_out_in,
  input wire logic capcomp_four_out_in,
  input wire logic capcomp_four_oe_in,
  input wire logic [1:0] general_io_out_in,
  input wire logic [1:0] general_io_oe_in,
  // Peripheral receive lines
  output ppfs_rx_t periph_rx_out,
  output logic [1:0] general_io_rx_out,
  // Shared pin interrupts and block interrupt
  output logic shared_pin_irq_zero_out,
  output logic shared_pin_irq_one_out,
  output logic irq_out
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [17:0] byte_addr(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction

  logic [7:0] pin_a_reg;
  logic [7:0] pin_b_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic [31:0] prdata_reg;

  wire hit_a = paddr_in == byte_addr(`PPFS_PIN_A_IDX);
  wire hit_b = paddr_in == byte_addr(`PPFS_PIN_B_IDX);
  wire hit_stat = paddr_in == byte_addr(`PPFS_IRQ_STAT_IDX);
  wire hit_mask = paddr_in == byte_addr(`PPFS_IRQ_MASK_IDX);
  wire hit_state = paddr_in == byte_addr(`PPFS_PIN_STATE_IDX);
  wire hit_any = hit_a | hit_b | hit_stat | hit_mask | hit_state;
  wire setup_ph = psel_in & ~penable_in;
  wire access_ph = psel_in & penable_in;
  wire wr_en = access_ph & pwrite_in & hit_any;

  // Zero wait state: read data is latched in setup, so access can finish at once
  assign pready_out = 1'b1;
  assign pslverr_out = access_ph & ~hit_any;
  assign prdata_out = prdata_reg;

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pin_lvl;

  ppfs_sync #(
    .W(2)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .async_in({pin_b_in, pin_a_in}),
    .level_out(pin_lvl)
  );

  wire lvl_a = pin_lvl[0];
  wire lvl_b = pin_lvl[1];

  // ----------------------------------------------------------------
  // Shared pin interrupt combining
  // ----------------------------------------------------------------
  // Any pin with its select bit set contributes; one pin may feed both lines
  wire irq_zero_next = (pin_a_reg[`PPFS_IRQ_ZERO_SRC_SEL] & lvl_a) |
                       (pin_b_reg[`PPFS_IRQ_ZERO_SRC_SEL] & lvl_b);
  wire irq_one_next = (pin_a_reg[`PPFS_IRQ_ONE_SRC_SEL] & lvl_a) |
                      (pin_b_reg[`PPFS_IRQ_ONE_SRC_SEL] & lvl_b);
  wire [1:0] ev_set;
  assign ev_set[`PPFS_EV_IRQ_ZERO] = irq_zero_next & ~shared_pin_irq_zero_out;
  assign ev_set[`PPFS_EV_IRQ_ONE] = irq_one_next & ~shared_pin_irq_one_out;

  // ----------------------------------------------------------------
  // Pad drive selection
  // ----------------------------------------------------------------
  // Fixed priority from bit 7 down keeps the pad sane if software sets two drivers
  ppfs_pad_t pad_a_next;
  ppfs_pad_t pad_b_next;

  always_comb begin
    pad_a_next = '{out: 1'b0, oe: 1'b0};
    if (pin_a_reg[`PPFS_PWM_CH_FOUR_OUT_SEL]) begin
      pad_a_next = '{out: pwm_ch_four_in, oe: 1'b1};
    end else if (pin_a_reg[`PPFS_I2C_MASTER_CLOCK_SEL]) begin
      pad_a_next = '{out: 1'b0, oe: i2c_master_clock_low_in};
    end else if (pin_a_reg[`PPFS_I2C_SLAVE_TWO_CLOCK_SEL]) begin
      pad_a_next = '{out: 1'b0, oe: i2c_slave_two_clock_low_in};
    end else if (pin_a_reg[`PPFS_BUZZER_OUT_SEL]) begin
      pad_a_next = '{out: buzzer_in, oe: 1'b1};
    end else if (pin_a_reg[`PPFS_SPI_CLOCK_SEL]) begin
      pad_a_next = '{out: spi_clock_in, oe: spi_is_master_in};
    end else if (pin_a_reg[`PPFS_GENERAL_IO_SEL]) begin
      pad_a_next = '{out: general_io_out_in[0], oe: general_io_oe_in[0]};
    end
  end

  // Receive-only functions leave the second pad undriven
  always_comb begin
    pad_b_next = '{out: 1'b0, oe: 1'b0};
    if (pin_b_reg[`PPFS_PWM_CH_FIVE_OUT_SEL]) begin
      pad_b_next = '{out: pwm_ch_five_in, oe: 1'b1};
    end else if (pin_b_reg[`PPFS_ENH_SERIAL_RX_SEL] | pin_b_reg[`PPFS_BASIC_SERIAL_RX_SEL]) begin
      pad_b_next = '{out: 1'b0, oe: 1'b0};
    end else if (pin_b_reg[`PPFS_CAPCOMP_FOUR_IO_SEL]) begin
      pad_b_next = '{out: capcomp_four_out_in, oe: capcomp_four_oe_in};
    end else if (pin_b_reg[`PPFS_SPI_MAIN_OUT_SEL]) begin
      pad_b_next = '{out: spi_main_out_in, oe: spi_is_master_in};
    end else if (pin_b_reg[`PPFS_GENERAL_IO_SEL]) begin
      pad_b_next = '{out: general_io_out_in[1], oe: general_io_oe_in[1]};
    end
  end

  // ----------------------------------------------------------------
  // Receive routing
  // ----------------------------------------------------------------
  // Deselected peripheral lines rest high, the idle level of serial, SPI and I2C lines; general I/O receive lines rest low
  ppfs_rx_t rx_next;
  assign rx_next.enh_serial_rx = pin_b_reg[`PPFS_ENH_SERIAL_RX_SEL] ? lvl_b : 1'b1;
  assign rx_next.basic_serial_rx = pin_b_reg[`PPFS_BASIC_SERIAL_RX_SEL] ? lvl_b : 1'b1;
  assign rx_next.capcomp_four_rx = pin_b_reg[`PPFS_CAPCOMP_FOUR_IO_SEL] ? lvl_b : 1'b1;
  assign rx_next.spi_main_out_rx = pin_b_reg[`PPFS_SPI_MAIN_OUT_SEL] ? lvl_b : 1'b1;
  assign rx_next.spi_clock_rx = pin_a_reg[`PPFS_SPI_CLOCK_SEL] ? lvl_a : 1'b1;
  assign rx_next.i2c_master_clock_rx = pin_a_reg[`PPFS_I2C_MASTER_CLOCK_SEL] ? lvl_a : 1'b1;
  assign rx_next.i2c_slave_two_clock_rx =
    pin_a_reg[`PPFS_I2C_SLAVE_TWO_CLOCK_SEL] ? lvl_a : 1'b1;
  wire [1:0] gpio_rx_next = {pin_b_reg[`PPFS_GENERAL_IO_SEL] & lvl_b,
                             pin_a_reg[`PPFS_GENERAL_IO_SEL] & lvl_a};

  // ----------------------------------------------------------------
  // Register read mux and write values
  // ----------------------------------------------------------------
  wire [31:0] rd_next = hit_a ? {24'h000000, pin_a_reg} :
                        hit_b ? {24'h000000, pin_b_reg} :
                        hit_stat ? {30'h0000000, irq_stat_reg} :
                        hit_mask ? {30'h0000000, irq_mask_reg} :
                        hit_state ? {28'h0000000, shared_pin_irq_one_out,
                                     shared_pin_irq_zero_out, pin_lvl} :
                        32'h00000000;
  // Set wins over a write-one clear in the same cycle
  wire [1:0] stat_clr = (wr_en & hit_stat) ? pwdata_in[1:0] : 2'h0;
  wire [1:0] stat_next = (irq_stat_reg & ~stat_clr) | ev_set;

  // Configuration registers
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      pin_a_reg <= `PPFS_PIN_RST;
      pin_b_reg <= `PPFS_PIN_RST;
      irq_mask_reg <= `PPFS_IRQ_RST;
    end else if (wr_en) begin
      if (hit_a) pin_a_reg <= pwdata_in[7:0];
      if (hit_b) pin_b_reg <= pwdata_in[7:0];
      if (hit_mask) irq_mask_reg <= pwdata_in[1:0];
    end
  end

  // Status, read data and interrupt line
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      irq_stat_reg <= `PPFS_IRQ_RST;
      prdata_reg <= 32'h00000000;
      irq_out <= 1'b0;
    end else begin
      irq_stat_reg <= stat_next;
      prdata_reg <= setup_ph ? rd_next : prdata_reg;
      irq_out <= |(stat_next & irq_mask_reg);
    end
  end

  // Registered pad drive, receive lines and shared interrupts
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      {pin_a_out, pin_a_oe_out} <= 2'h0;
      {pin_b_out, pin_b_oe_out} <= 2'h0;
      periph_rx_out <= '1;
      general_io_rx_out <= 2'h0;
      shared_pin_irq_zero_out <= 1'b0;
      shared_pin_irq_one_out <= 1'b0;
    end else begin
      {pin_a_out, pin_a_oe_out} <= pad_a_next;
      {pin_b_out, pin_b_oe_out} <= pad_b_next;
      periph_rx_out <= rx_next;
      general_io_rx_out <= gpio_rx_next;
      shared_pin_irq_zero_out <= irq_zero_next;
      shared_pin_irq_one_out <= irq_one_next;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);

  a_pin_a_write: assert property (
    access_ph && pwrite_in && hit_a |=> pin_a_reg == $past(pwdata_in[7:0]))
    else $error("first pin register did not take write data");
  a_pin_b_readback: assert property (
    setup_ph && !pwrite_in && hit_b ##1 access_ph |-> prdata_out == {24'h000000, pin_b_reg})
    else $error("second pin register read mismatch");
  a_pwm5_drive: assert property (
    pin_b_reg[7] |=> pin_b_oe_out && pin_b_out == $past(pwm_ch_five_in))
    else $error("PWM five not driving second pin");
  a_enh_rx_route: assert property (
    pin_b_reg[6] |=> periph_rx_out.enh_serial_rx == $past(lvl_b))
    else $error("enhanced serial receive not routed");
  a_basic_rx_route: assert property (
    pin_b_reg[5] && !pin_b_reg[7] |=> !pin_b_oe_out && periph_rx_out.basic_serial_rx == $past(lvl_b))
    else $error("basic serial receive not routed");
  a_capcomp_io: assert property (
    pin_b_reg[7:4] == 4'h1 |=> pin_b_oe_out == $past(capcomp_four_oe_in)
      && pin_b_out == $past(capcomp_four_out_in))
    else $error("capture compare four not connected");
  a_mosi_role: assert property (
    pin_b_reg[7:3] == 5'h01 |=> pin_b_oe_out == $past(spi_is_master_in))
    else $error("MOSI direction wrong");
  a_irq_one_comb: assert property (
    shared_pin_irq_one_out == $past((pin_a_reg[2] & lvl_a) | (pin_b_reg[2] & lvl_b)))
    else $error("shared interrupt one wrong");
  a_irq_both_lines: assert property (
    pin_a_reg[2:1] == 2'h3 && lvl_a |=> shared_pin_irq_zero_out && shared_pin_irq_one_out)
    else $error("pin did not feed both shared interrupts");
  a_gpio_off: assert property (
    pin_a_reg == 8'h00 |=> !pin_a_oe_out && general_io_rx_out[0] == 1'b0)
    else $error("first pin driven with no function");
  a_buzzer_drive: assert property (
    pin_a_reg[7:4] == 4'h1 |=> pin_a_oe_out && pin_a_out == $past(buzzer_in))
    else $error("buzzer not driving first pin");
  a_scl_open_drain: assert property (
    pin_a_reg[7:6] == 2'h1 |=> !pin_a_out && pin_a_oe_out == $past(i2c_master_clock_low_in))
    else $error("I2C clock not open-drain");
  a_pwm4_drive: assert property (
    pin_a_reg[7] |=> pin_a_oe_out && pin_a_out == $past(pwm_ch_four_in))
    else $error("PWM four not driving first pin");
  a_irq_output: assert property (
    irq_out == $past(|(stat_next & irq_mask_reg)))
    else $error("interrupt output mismatch");
  // Routing and interrupt checks for cases that the register checks above leave open
  a_irq_zero_feed: assert property (
    (pin_a_reg[1] && lvl_a) || (pin_b_reg[1] && lvl_b) |=> shared_pin_irq_zero_out)
    else $error("pin did not feed shared interrupt zero");
  a_irq_one_join: assert property (
    pin_a_reg[2] && pin_b_reg[2] && !lvl_a && lvl_b |=> shared_pin_irq_one_out)
    else $error("second pin did not join shared interrupt one");
  a_rx_undriven: assert property (
    pin_b_reg[7:6] == 2'h1 |=> !pin_b_oe_out)
    else $error("second pin driven while a receive input");
  a_gpio_rx: assert property (
    pin_b_reg[0] |=> general_io_rx_out[1] == $past(lvl_b))
    else $error("general I/O receive not routed");
  a_stat_set_wins: assert property (
    ev_set != 2'h0 |=> (irq_stat_reg & $past(ev_set)) == $past(ev_set))
    else $error("status event lost");
  a_scl_slave: assert property (
    pin_a_reg[7:5] == 3'h1 |=> !pin_a_out
      && pin_a_oe_out == $past(i2c_slave_two_clock_low_in))
    else $error("I2C slave clock not open-drain");
  a_spi_clock: assert property (
    pin_a_reg[7:3] == 5'h01 |=> pin_a_oe_out == $past(spi_is_master_in)
      && pin_a_out == $past(spi_clock_in))
    else $error("SPI clock not on first pin");
  a_scl_rx: assert property (
    pin_a_reg[6] |=> periph_rx_out.i2c_master_clock_rx == $past(lvl_a))
    else $error("I2C master clock not received");

  c_pwm5_sel: cover property (pin_b_reg[7] ##1 pin_b_oe_out);
  c_irq_raised: cover property ($rose(irq_out));
  c_unmapped: cover property (pslverr_out);
  c_irq_both: cover property (shared_pin_irq_zero_out && shared_pin_irq_one_out);
  c_spi_slave: cover property (pin_b_reg[3] && !spi_is_master_in);

endmodule

// file: tb/ppfs_pad_model.sv
// External circuitry on the two pads: pull-ups plus bench-commanded drivers
`timescale 1ns/1ps
module ppfs_pad_model (
  // Pad drive from the block
  input wire logic [1:0] pad_out_in,
  input wire logic [1:0] pad_oe_in,
  // External drivers commanded by the bench
  input wire logic [1:0] ext_en_in,
  input wire logic [1:0] ext_level_in,
  // Resolved wire levels
  output logic [1:0] wire_out
);
  // Pull-up wins only when nobody drives, so a released open-drain clock reads high
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      wire_out[i] = pad_oe_in[i] ? pad_out_in[i] :
                    (ext_en_in[i] ? ext_level_in[i] : 1'b1);
    end
  end
endmodule

// file: tb/tb_port_pin_function_select.sv
// Self-checking bench for the two-pin function select block
`timescale 1ns/1ps
`include "ppfs_regs.svh"
module tb_port_pin_function_select;
  import ppfs_pkg::*;
  // ----------------------------------------------------------------
  // Row: pin, config, followed sources, oe kind (0 off, 1 on, 2 follows), out held low
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pin;
    logic [7:0] val;
    logic [12:0] mask;
    logic [1:0] oek;
    logic oz;
  } ppfs_row_t;
  localparam logic [17:0] A_ADDR = {`PPFS_PIN_A_IDX, 2'b00};
  localparam logic [17:0] B_ADDR = {`PPFS_PIN_B_IDX, 2'b00};
  localparam logic [17:0] ST_ADDR = {`PPFS_IRQ_STAT_IDX, 2'b00};
  localparam logic [17:0] MK_ADDR = {`PPFS_IRQ_MASK_IDX, 2'b00};
  localparam logic [17:0] PS_ADDR = {`PPFS_PIN_STATE_IDX, 2'b00};
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Source bits: pwm4, pwm5, buzzer, i2c lows, spi clk/out, capcomp out/oe, gpio out, gpio oe
  logic [12:0] src = 13'h0000;
  logic [1:0] ext_en = 2'b00;
  logic [1:0] ext_lvl = 2'b00;
  logic spi_mst = 1'b1;
  logic [1:0] pad_out;
  logic [1:0] pad_oe;
  logic [1:0] pin_lvl;
  ppfs_rx_t rx;
  logic [1:0] gio_rx;
  logic irq0;
  logic irq1;
  logic irq;
  logic [31:0] q;
  logic e;
  logic eo;
  logic got;
  int fail_count = 0;
  int check_count = 0;
  ppfs_row_t rows [14] = '{
    '{1'b0, 8'h80, 13'h0001, 2'h1, 1'b0}, '{1'b0, 8'h40, 13'h0008, 2'h2, 1'b1},
    '{1'b0, 8'h20, 13'h0010, 2'h2, 1'b1}, '{1'b0, 8'h10, 13'h0004, 2'h1, 1'b0},
    '{1'b0, 8'h08, 13'h0020, 2'h1, 1'b0}, '{1'b0, 8'h01, 13'h0A00, 2'h2, 1'b0},
    '{1'b0, 8'h06, 13'h0000, 2'h0, 1'b0}, '{1'b1, 8'h80, 13'h0002, 2'h1, 1'b0},
    '{1'b1, 8'h40, 13'h0000, 2'h0, 1'b0}, '{1'b1, 8'h20, 13'h0000, 2'h0, 1'b0},
    '{1'b1, 8'h10, 13'h0180, 2'h2, 1'b0}, '{1'b1, 8'h08, 13'h0040, 2'h1, 1'b0},
    '{1'b1, 8'h01, 13'h1400, 2'h2, 1'b0}, '{1'b1, 8'h00, 13'h0000, 2'h0, 1'b0}};
  logic [7:0] rx_cfg [4] = '{8'h40, 8'h20, 8'h01, 8'h08};

  // SPI role is master for the table rows; the slave direction is a hand-written case
  ppfs_top i_dut (
    .ref_clk_in(ref_clk), .rstn_in(rstn), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .pin_a_in(pin_lvl[0]), .pin_a_out(pad_out[0]), .pin_a_oe_out(pad_oe[0]),
    .pin_b_in(pin_lvl[1]), .pin_b_out(pad_out[1]), .pin_b_oe_out(pad_oe[1]),
    .pwm_ch_four_in(src[0]), .pwm_ch_five_in(src[1]), .buzzer_in(src[2]),
    .i2c_master_clock_low_in(src[3]), .i2c_slave_two_clock_low_in(src[4]),
    .spi_is_master_in(spi_mst), .spi_clock_in(src[5]), .spi_main_out_in(src[6]),
    .capcomp_four_out_in(src[7]), .capcomp_four_oe_in(src[8]),
    .general_io_out_in(src[10:9]), .general_io_oe_in(src[12:11]),
    .periph_rx_out(rx), .general_io_rx_out(gio_rx),
    .shared_pin_irq_zero_out(irq0), .shared_pin_irq_one_out(irq1), .irq_out(irq));
  ppfs_pad_model i_pad_model (.pad_out_in(pad_out), .pad_oe_in(pad_oe),
    .ext_en_in(ext_en), .ext_level_in(ext_lvl), .wire_out(pin_lvl));

  // ----------------------------------------------------------------
  // Clock, shared tasks
  // ----------------------------------------------------------------
  always #4 ref_clk = ~ref_clk;

  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  // One APB transfer; it waits for ready as long as it takes, the watchdog ends a hang
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    chk(psel === 1'b1 && penable === 1'b1 && paddr === a, "request dropped");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [17:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h00000000);
    chk(q === x && e === xe, "read value");
  endtask

  // Filter and output register need about five edges; eight leaves margin
  task automatic settle();
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    // Each row twice: followed sources low with the rest high, then inverted
    for (int i = 0; i < 14; i++) begin
      apb(1'b1, rows[i].pin ? B_ADDR : A_ADDR, {24'h000000, rows[i].val});
      for (int p = 0; p < 2; p++) begin
        @(posedge ref_clk);
        src <= p ? rows[i].mask : ~rows[i].mask;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        eo = (rows[i].oek == 2'h2) ? p[0] : rows[i].oek[0];
        chk(pad_oe[rows[i].pin] === eo, "pad enable");
        if (eo) chk(pad_out[rows[i].pin] === (rows[i].oz ? 1'b0 : p[0]), "pad level");
      end
    end
    apb(1'b1, A_ADDR, 32'hFFFFFF5A);
    rd(A_ADDR, 32'h0000005A, 1'b0);
    apb(1'b1, B_ADDR, 32'h000000A5);
    rd(B_ADDR, 32'h000000A5, 1'b0);
    rd(18'h00000, 32'h00000000, 1'b1);
    // Receive routing from pin B, plus pin A's I2C master and SPI clock lines, driven from outside
    src <= 13'h0000;
    ext_en <= 2'b11;
    for (int k = 0; k < 4; k++) begin
      spi_mst <= (k != 3);
      apb(1'b1, B_ADDR, {24'h000000, rx_cfg[k]});
      for (int v = 0; v < 2; v++) begin
        ext_lvl <= {v[0], v[0]};
        settle();
        got = (k == 0) ? rx.enh_serial_rx : (k == 1) ? rx.basic_serial_rx :
              (k == 2) ? gio_rx[1] : rx.spi_main_out_rx;
        chk(got === v[0], "receive level");
        chk((rx.enh_serial_rx & rx.basic_serial_rx) === (k < 2 ? v[0] : 1'b1), "idle rx");
        chk(rx.i2c_master_clock_rx === v[0] && rx.spi_clock_rx === v[0], "pin a rx");
        if (k == 3) chk(pad_oe[1] === 1'b0, "slave mosi driven");
      end
    end
    // Shared interrupts: pin A feeds both, pin B joins interrupt one
    ext_lvl <= 2'b00;
    apb(1'b1, A_ADDR, 32'h00000006);
    apb(1'b1, B_ADDR, 32'h00000004);
    apb(1'b1, MK_ADDR, 32'h00000003);
    settle();
    apb(1'b1, ST_ADDR, 32'h00000003);
    settle();
    chk(irq === 1'b0 && irq0 === 1'b0, "irq idle");
    ext_lvl <= 2'b01;
    settle();
    chk(irq0 === 1'b1 && irq1 === 1'b1 && irq === 1'b1, "both shared");
    rd(PS_ADDR, 32'h0000000D, 1'b0);
    rd(ST_ADDR, 32'h00000003, 1'b0);
    apb(1'b1, ST_ADDR, 32'h00000001);
    rd(ST_ADDR, 32'h00000002, 1'b0);
    apb(1'b1, MK_ADDR, 32'h00000000);
    ext_lvl <= 2'b00;
    settle();
    chk(irq === 1'b0 && irq1 === 1'b0, "masked");
    apb(1'b1, ST_ADDR, 32'h00000003);
    ext_lvl <= 2'b10;
    settle();
    chk(irq1 === 1'b1 && irq0 === 1'b0 && irq === 1'b0, "pin b shared");
    apb(1'b1, MK_ADDR, 32'h00000002);
    settle();
    chk(irq === 1'b1, "unmasked");
    // Reset in mid-run returns registers and pads to rest
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(A_ADDR, 32'h00000000, 1'b0);
    rd(B_ADDR, 32'h00000000, 1'b0);
    chk(pad_oe === 2'b00 && gio_rx === 2'b00, "pads at rest");
    give_verdict();
  end

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #(20000 * 8);
    fail_count++;
    give_verdict();
  end
endmodule
